// ===== crosspoint_pkg.sv
// Constants and types shared by the crosspoint serial control port
package crosspoint_pkg;

    // Matrix shape
    localparam int OUTPUTS     = 16;
    localparam int SEL_W       = 4;
    localparam int CFG_W       = 6;
    localparam int CHAIN_W     = 96;
    localparam int SINGLE_W    = 14;
    localparam int STRAP_W     = 4;

    // Per-output configuration field positions
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_GAIN    = 4;
    localparam int CFG_EN      = 5;

    // Single-output word field positions
    localparam int SGL_ADR_LSB = 10;
    localparam int SGL_OUT_LSB = 6;
    localparam int SGL_CFG_LSB = 0;

    // Mode select levels
    localparam logic MODE_FULL   = 1'b1;
    localparam logic MODE_SINGLE = 1'b0;

    // Power-up values of the matrix latches
    localparam logic [OUTPUTS*SEL_W-1:0] RST_SEL  = 64'h0;
    localparam logic [OUTPUTS-1:0]       RST_GAIN = 16'h0;
    localparam logic [OUTPUTS-1:0]       RST_OE   = 16'h0;

    // Timing
    localparam int SYS_CLK_MHZ       = 200;
    localparam int T_UPD_LOW_MIN_NS  = 100;
    localparam int UPD_LOW_MIN_CYC   =
        (T_UPD_LOW_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int UPD_QUAL_CYC      =
        (UPD_LOW_MIN_CYC / 4 < 1) ? 1 : UPD_LOW_MIN_CYC / 4;
    localparam int QUAL_W            = 5;
    localparam int STRAP_SETTLE_CYC  = 3;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_QUAL  = 4'h2,
        ST_APPLY = 4'h4,
        ST_HOLD  = 4'h8
    } upd_state_e;

endpackage

// ===== crosspoint_serial_control_port.sv
// Serial control port of a 16x16 video crosspoint switch
`timescale 1ns/10ps

// How it works
// RULE1 - Chip address comes from four board straps, captured after reset
// RULE2 - Full-load mode shifts through 96 bits; the last bit drives serial out
// RULE3 - Single-output mode passes serial in straight to serial out
// RULE4 - Address match flag goes low after own address is recognised
// RULE5 - Host holds interface enable low to clock data in
// RULE6 - Mode pin high selects full-load, low selects single-output
// RULE7 - Serial input is sampled on each falling serial clock edge
// RULE8 - Update strobe low copies shifted configuration into matrix latches
// RULE9 - Single-output update compares address to bits 13..10 first
// RULE10 - Reset pin low restores defaults and disables every output
// RULE11 - Interface enable high freezes shift registers and latches
module crosspoint_serial_control_port
    import crosspoint_pkg::*;
#(
    parameter int unsigned QUAL_CYC = UPD_QUAL_CYC
) (
    input  wire logic                       SYS_CLK,
    input  wire logic                       RESET,
    input  wire logic                       SCLK,
    input  wire logic                       CE_N,
    input  wire logic                       DIN,
    input  wire logic                       MODE,
    input  wire logic                       UPDATE_N,
    input  wire logic                       MATRIX_RESET_N,
    input  wire logic [STRAP_W-1:0]         CHIP_ADDRESS_STRAPS,
    output logic                            DOUT,
    output logic                            ADDRESS_MATCH_N,
    output logic [OUTPUTS*SEL_W-1:0]        MATRIX_INPUT_SEL,
    output logic [OUTPUTS-1:0]              MATRIX_GAIN,
    output logic [OUTPUTS-1:0]              MATRIX_OUTPUT_ENABLE,
    output logic [STRAP_W-1:0]              CHIP_ADDRESS,
    output logic                            UPDATE_APPLIED,
    output logic                            UPDATE_REJECTED
);

    // ------------------------------------------------------------------
    // Link domain: runs on the serial clock, falling edge
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CHAIN_W-1:0]  chain;
        logic [SINGLE_W-1:0] single;
    } link_s;

    link_s link_q;
    link_s link_d;

    always_comb begin
        link_d = link_q;
        // Frozen while disabled or while an update is in progress
        if (!CE_N && UPDATE_N) begin // RULE11 RULE5
            if (MODE == MODE_FULL) begin // RULE6
                link_d.chain = {link_q.chain[CHAIN_W-2:0], DIN}; // RULE2
            end else begin
                link_d.single = {link_q.single[SINGLE_W-2:0], DIN};
            end
        end
    end

    // Serial clock may stop, so this domain resets from the pin itself
    always_ff @(negedge SCLK or negedge MATRIX_RESET_N) begin // RULE7
        if (!MATRIX_RESET_N) begin
            link_q <= '0; // RULE10
        end else begin
            link_q <= link_d;
        end
    end

    // Pass-through keeps every chained device seeing the same word
    assign DOUT = (MODE == MODE_FULL) ? link_q.chain[CHAIN_W-1] // RULE2
                                      : DIN; // RULE3

    // ------------------------------------------------------------------
    // System domain: update sequencing and matrix latches
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                 rst_n_sy;
        logic [1:0]                 upd_n_sy;
        logic [1:0]                 ce_n_sy;
        logic [1:0]                 mode_sy;
        logic [STRAP_W-1:0]         strap_meta;
        logic [STRAP_W-1:0]         strap_sync;
        logic [STRAP_W-1:0]         chip_addr;
        logic [1:0]                 strap_age;
        upd_state_e                 state;
        logic [QUAL_W-1:0]          qual_cnt;
        logic [OUTPUTS*SEL_W-1:0]   sel;
        logic [OUTPUTS-1:0]         gain;
        logic [OUTPUTS-1:0]         oe;
        logic                       match_n;
        logic                       applied;
        logic                       rejected;
    } sys_s;

    sys_s sys_q;
    sys_s sys_d;

    logic                     pin_rst_n;
    logic                     upd_n;
    logic                     ce_n;
    logic                     mode_full;
    logic                     addr_ok;
    logic [STRAP_W-1:0]       word_addr;
    logic [3:0]               word_out;
    logic [CFG_W-1:0]         word_cfg;
    logic [OUTPUTS-1:0]       cfg_we;
    logic [OUTPUTS*SEL_W-1:0] new_sel;
    logic [OUTPUTS-1:0]       new_gain;
    logic [OUTPUTS-1:0]       new_oe;

    assign pin_rst_n = sys_q.rst_n_sy[1];
    assign upd_n     = sys_q.upd_n_sy[1];
    assign ce_n      = sys_q.ce_n_sy[1];
    assign mode_full = (sys_q.mode_sy[1] == MODE_FULL); // RULE6

    // Shift words are read only once the strobe has been qualified low;
    // shifting is held off then, so they are stable across the crossing.
    assign word_addr = link_q.single[SGL_ADR_LSB +: STRAP_W];
    assign word_out  = link_q.single[SGL_OUT_LSB +: 4];
    assign word_cfg  = link_q.single[SGL_CFG_LSB +: CFG_W];
    assign addr_ok   = (word_addr == sys_q.chip_addr); // RULE9

    genvar k;
    generate
        for (k = 0; k < OUTPUTS; k++) begin : g_out
            logic [CFG_W-1:0] cfg;

            assign cfg = mode_full ? link_q.chain[k*CFG_W +: CFG_W]
                                   : word_cfg;
            // Only the addressed output changes in single-output mode
            assign cfg_we[k] = mode_full ||
                               (addr_ok && (word_out == 4'(k))); // RULE9
            assign new_sel[k*SEL_W +: SEL_W] = cfg_we[k]
                ? cfg[CFG_SEL_LSB +: SEL_W]
                : sys_q.sel[k*SEL_W +: SEL_W];
            assign new_gain[k] = cfg_we[k] ? cfg[CFG_GAIN]
                                           : sys_q.gain[k];
            assign new_oe[k]   = cfg_we[k] ? cfg[CFG_EN]
                                           : sys_q.oe[k];
        end
    endgenerate

    always_comb begin
        sys_d          = sys_q;
        sys_d.applied  = 1'b0;
        sys_d.rejected = 1'b0;

        sys_d.rst_n_sy   = {sys_q.rst_n_sy[0], MATRIX_RESET_N};
        sys_d.upd_n_sy   = {sys_q.upd_n_sy[0], UPDATE_N};
        sys_d.ce_n_sy    = {sys_q.ce_n_sy[0], CE_N};
        sys_d.mode_sy    = {sys_q.mode_sy[0], MODE};
        sys_d.strap_meta = CHIP_ADDRESS_STRAPS;
        sys_d.strap_sync = sys_q.strap_meta;

        // Straps are static; take them once the synchroniser has filled
        if (sys_q.strap_age != 2'(STRAP_SETTLE_CYC)) begin
            sys_d.strap_age = sys_q.strap_age + 2'h1;
            if (sys_q.strap_age == 2'(STRAP_SETTLE_CYC - 1)) begin
                sys_d.chip_addr = sys_q.strap_sync; // RULE1
            end
        end

        case (sys_q.state)
            ST_IDLE: begin
                if (!upd_n && !ce_n) begin
                    sys_d.state    = ST_QUAL;
                    sys_d.qual_cnt = QUAL_W'(1);
                end
            end
            ST_QUAL: begin
                // Short glitches on the strobe never reach the latches
                if (upd_n || ce_n) begin // RULE11
                    sys_d.state = ST_IDLE;
                end else if (sys_q.qual_cnt >= QUAL_W'(QUAL_CYC)) begin
                    sys_d.state = ST_APPLY;
                end else begin
                    sys_d.qual_cnt = sys_q.qual_cnt + QUAL_W'(1);
                end
            end
            ST_APPLY: begin
                sys_d.sel   = new_sel; // RULE8
                sys_d.gain  = new_gain;
                sys_d.oe    = new_oe;
                sys_d.state = ST_HOLD;
                if (mode_full) begin
                    sys_d.match_n = 1'b1;
                    sys_d.applied = 1'b1;
                end else if (addr_ok) begin
                    sys_d.match_n = 1'b0; // RULE4
                    sys_d.applied = 1'b1;
                end else begin
                    sys_d.match_n  = 1'b1;
                    sys_d.rejected = 1'b1;
                end
            end
            ST_HOLD: begin
                // One transfer per strobe, however long it is held low
                if (upd_n) begin
                    sys_d.state = ST_IDLE;
                end
            end
            default: begin
                sys_d.state = ST_IDLE;
            end
        endcase

        // Reset pin beats any update in flight
        if (!pin_rst_n) begin
            sys_d.sel     = RST_SEL; // RULE10
            sys_d.gain    = RST_GAIN;
            sys_d.oe      = RST_OE;
            sys_d.match_n = 1'b1;
            sys_d.state   = ST_IDLE;
            sys_d.applied = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            sys_q          <= '0;
            sys_q.upd_n_sy <= 2'b11;
            sys_q.ce_n_sy  <= 2'b11;
            sys_q.match_n  <= 1'b1;
            sys_q.state    <= ST_IDLE;
            sys_q.sel      <= RST_SEL; // RULE10
            sys_q.gain     <= RST_GAIN;
            sys_q.oe       <= RST_OE;
        end else begin
            sys_q <= sys_d;
        end
    end

    assign ADDRESS_MATCH_N      = sys_q.match_n;
    assign MATRIX_INPUT_SEL     = sys_q.sel;
    assign MATRIX_GAIN          = sys_q.gain;
    assign MATRIX_OUTPUT_ENABLE = sys_q.oe;
    assign CHIP_ADDRESS         = sys_q.chip_addr;
    assign UPDATE_APPLIED       = sys_q.applied;
    assign UPDATE_REJECTED      = sys_q.rejected;

endmodule // crosspoint_serial_control_port

// ===== crosspoint_serial_control_port_monitor.sv
// Concurrent checks on the crosspoint serial control port
`timescale 1ns/10ps
module crosspoint_serial_control_port_monitor
    import crosspoint_pkg::*;
(
    input wire logic               SYS_CLK,
    input wire logic               RESET,
    input wire logic               DIN,
    input wire logic               MODE,
    input wire logic               MATRIX_RESET_N,
    input wire logic               DOUT,
    input wire logic               ADDRESS_MATCH_N,
    input wire logic [OUTPUTS-1:0] MATRIX_OUTPUT_ENABLE,
    input wire logic               UPDATE_APPLIED,
    input wire logic               UPDATE_REJECTED
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    // Reset pin seen low long enough for the synchroniser
    sequence s_mreset_low;
        !MATRIX_RESET_N [*3];
    endsequence
    sequence s_any_pulse;
        UPDATE_APPLIED || UPDATE_REJECTED;
    endsequence
    chk_dout_pass: assert property (!MODE |-> DOUT == DIN)
        else $error("serial out does not follow serial in");
    chk_reset_state: assert property (disable iff (1'b0)
        RESET |=> MATRIX_OUTPUT_ENABLE == RST_OE && ADDRESS_MATCH_N)
        else $error("outputs not disabled after reset");
    chk_mreset_clear: assert property (s_mreset_low |=>
        MATRIX_OUTPUT_ENABLE == RST_OE)
        else $error("reset pin did not disable outputs");
    chk_latch_hold: assert property ($changed(MATRIX_OUTPUT_ENABLE)
        && MATRIX_RESET_N && $past(MATRIX_RESET_N, 3) |-> UPDATE_APPLIED)
        else $error("latches changed without an update");
    chk_pulse_once: assert property (s_any_pulse |=>
        !(UPDATE_APPLIED || UPDATE_REJECTED))
        else $error("update pulse longer than one cycle");
    chk_reject_flag: assert property (UPDATE_REJECTED |->
        ADDRESS_MATCH_N && !UPDATE_APPLIED && MODE == MODE_SINGLE)
        else $error("rejected update with wrong flags");
    chk_match_cause: assert property ($fell(ADDRESS_MATCH_N) |->
        UPDATE_APPLIED && MODE == MODE_SINGLE)
        else $error("match flag fell without single update");
    chk_full_clears: assert property (UPDATE_APPLIED
        && MODE == MODE_FULL |-> ADDRESS_MATCH_N)
        else $error("match flag low after full load");
endmodule // crosspoint_serial_control_port_monitor

bind crosspoint_serial_control_port crosspoint_serial_control_port_monitor
    i_mon (.SYS_CLK(SYS_CLK), .RESET(RESET), .DIN(DIN), .MODE(MODE),
    .MATRIX_RESET_N(MATRIX_RESET_N), .DOUT(DOUT),
    .ADDRESS_MATCH_N(ADDRESS_MATCH_N),
    .MATRIX_OUTPUT_ENABLE(MATRIX_OUTPUT_ENABLE),
    .UPDATE_APPLIED(UPDATE_APPLIED), .UPDATE_REJECTED(UPDATE_REJECTED));

// ===== crosspoint_host_model.sv
// Host controller model driving the serial link and update strobe
`timescale 1ns/10ps
module crosspoint_host_model (
    output logic sclk,
    output logic ce_n,
    output logic din,
    output logic update_n
);
    initial begin
        sclk = 1'b1;
        ce_n = 1'b1;
        din = 1'b0;
        update_n = 1'b1;
    end
    // Clock stands still between frames; MSB first
    task automatic shift(input logic [95:0] w, input int n, input logic ce);
        #97.3 ce_n = ce;
        for (int i = n - 1; i >= 0; i--) begin
            din = w[i];
            #16 sclk = 1'b0;
            #16 sclk = 1'b1;
        end
        // Held data runs out, so stop showing the last bit
        #100 din = ~din;
    endtask
    task automatic update();
        ce_n = 1'b0;
        update_n = 1'b0;
        #100 update_n = 1'b1;
        #100;
    endtask
endmodule // crosspoint_host_model

// ===== tb_crosspoint_serial_control_port.sv
// Self-checking testbench of the crosspoint serial control port
`timescale 1ns/10ps
module tb_crosspoint_serial_control_port
    import crosspoint_pkg::*;
;
    logic        sys_clk, reset, mode, mreset_n;
    logic [3:0]  straps, chip_adr;
    wire         sclk, ce_n, din, update_n, dout, match_n, applied, rejected;
    wire  [63:0] sel;
    wire  [15:0] gain, oe;
    logic [63:0] e_sel;
    logic [15:0] e_gain, e_oe;
    logic [95:0] w;
    int          errors, n_tests;

    crosspoint_host_model i_crosspoint_host_model (.sclk(sclk),
        .ce_n(ce_n), .din(din), .update_n(update_n));
    crosspoint_serial_control_port i_crosspoint_serial_control_port (
        .SYS_CLK(sys_clk), .RESET(reset), .SCLK(sclk), .CE_N(ce_n),
        .DIN(din), .MODE(mode), .UPDATE_N(update_n),
        .MATRIX_RESET_N(mreset_n), .CHIP_ADDRESS_STRAPS(straps),
        .DOUT(dout), .ADDRESS_MATCH_N(match_n), .MATRIX_INPUT_SEL(sel),
        .MATRIX_GAIN(gain), .MATRIX_OUTPUT_ENABLE(oe),
        .CHIP_ADDRESS(chip_adr), .UPDATE_APPLIED(applied),
        .UPDATE_REJECTED(rejected));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic set_cfg(input int k, input logic [5:0] c);
        e_sel[4*k +: 4] = c[3:0];
        e_gain[k] = c[4];
        e_oe[k] = c[5];
    endtask
    task automatic check_matrix();
        chk(sel, e_sel);
        chk({48'h0, gain}, {48'h0, e_gain});
        chk({48'h0, oe}, {48'h0, e_oe});
    endtask
    // Single word: address, output number, config
    task automatic single(input logic [3:0] a, input logic [3:0] o,
                          input logic [5:0] c);
        i_crosspoint_host_model.shift({82'h0, a, o, c}, SINGLE_W, 1'b0);
        // Let the pass-through path settle after the last data change
        #1;
        chk({63'h0, dout}, {63'h0, ~c[0]});
        i_crosspoint_host_model.update();
    endtask

    initial begin
        errors = 0;
        n_tests = 0;
        reset = 1'b1;
        mode = MODE_FULL;
        mreset_n = 1'b1;
        straps = 4'ha;
        e_sel = RST_SEL;
        e_gain = RST_GAIN;
        e_oe = RST_OE;
        repeat (8) @(posedge sys_clk);
        #1 reset = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        check_matrix();
        chk({63'h0, match_n}, 64'h1);
        chk({60'h0, chip_adr}, 64'ha);
        for (int k = 0; k < OUTPUTS; k++) begin
            w[6*k +: 6] = {1'b1, k[0], 4'(15 - k)};
            set_cfg(k, w[6*k +: 6]);
        end
        i_crosspoint_host_model.shift(w, CHAIN_W, 1'b0);
        chk({63'h0, dout}, {63'h0, w[95]});
        i_crosspoint_host_model.update();
        check_matrix();
        // Disabled interface: chain and latches must keep the old word
        i_crosspoint_host_model.shift(~w, CHAIN_W, 1'b1);
        chk({63'h0, dout}, {63'h0, w[95]});
        i_crosspoint_host_model.update();
        check_matrix();
        @(posedge sys_clk);
        #1 mode = MODE_SINGLE;
        single(4'ha, 4'h3, 6'h25);
        set_cfg(3, 6'h25);
        check_matrix();
        chk({63'h0, match_n}, 64'h0);
        single(4'h5, 4'h7, 6'h3e);
        check_matrix();
        chk({63'h0, match_n}, 64'h1);
        @(posedge sys_clk);
        #1 mreset_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 mreset_n = 1'b1;
        e_sel = RST_SEL;
        e_gain = RST_GAIN;
        e_oe = RST_OE;
        check_matrix();
        test_done();
    end
    // Run takes under 9 us of link traffic
    initial begin
        #50000;
        errors++;
        test_done();
    end
endmodule // tb_crosspoint_serial_control_port
